/* File: rtl/ucode_dl_ctrl.sv */
// buffer-write microcode download and deferred activation controller
`timescale 1ns/1ps
`default_nettype none
module ucode_dl_ctrl
  import ucode_dl_pkg::*;
#(
  parameter int LEN_W = 24
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic [1:0] HRESP,
  output logic SAVE_STROBE,
  output logic SELF_RESET,
  output logic ACTIVATE,
  output logic SPIN_UP,
  output logic UNIT_ATTENTION,
  output logic ECHO_VALID,
  output logic [3:0] POWER_COND
);

  typedef enum logic [1:0] {
    ACT_IDLE,
    ACT_SPIN,
    ACT_FIRE
  } act_state_type;

  logic wr_pend;
  logic [7:0] addr_q;
  logic [31:0] len_reg;
  logic [LEN_W-1:0] image_size;
  logic [LEN_W-1:0] received;
  logic seg_restart;
  logic seg_err_seen;
  sense_type sense;
  logic cmd_done;
  defer_kind_type defer_kind;
  logic [2:0] sel_bits;
  logic low_power;
  act_state_type act_state;
  logic act_via_ua;
  logic act_via_ssu;
  logic act_via_reset_fmt;
  logic [3:0] ssu_pc;
  logic ssu_pc_valid;

  // decoded write pulses
  logic cmd_go;
  logic ev_go;
  logic [4:0] mode;
  logic [7:0] buf_id;
  logic [7:0] spec;
  logic [31:0] ev;
  logic seg_len_ok;
  logic seg_complete;
  logic act_req;
  logic act_req_ua;

  assign cmd_go = wr_pend && addr_q == OFS_CMD && HWDATA[CMD_GO_BIT];
  assign ev_go = wr_pend && addr_q == OFS_EVENT;
  assign ev = ev_go ? HWDATA : 32'h0;
  assign mode = HWDATA[CMD_MODE_LSB +: 5];
  assign buf_id = HWDATA[CMD_ID_LSB +: 8];
  assign spec = HWDATA[CMD_SPEC_LSB +: 8];
  // segment must be non-zero and 4K aligned; offset never consulted
  assign seg_len_ok = len_reg[SEG_ALIGN_BITS-1:0] == '0 &&
    len_reg != 32'h0;
  assign seg_complete = (seg_restart ? LEN_W'(0) : received) +
    len_reg[LEN_W-1:0] == image_size;

  // activation triggers: select-mode gated by its select bits
  always_comb
  begin
    act_req = 1'b0;
    act_req_ua = 1'b0;
    if (cmd_go && mode == MODE_ACTIVATE)
      act_req = 1'b1;
    if (defer_kind == DEF_SELECT)
    begin
      if (ev[EV_POWER_ON] && sel_bits[2])
        act_req = 1'b1;
      if (ev[EV_HARD_RESET] && sel_bits[1])
      begin
        act_req = 1'b1;
        act_req_ua = 1'b1;
      end
      if (ev[EV_VENDOR] && sel_bits[0])
        act_req = 1'b1;
    end
    if (defer_kind == DEF_PLAIN)
    begin
      if (ev[EV_POWER_ON])
        act_req = 1'b1;
      if (ev[EV_HARD_RESET] || ev[EV_SSU] || ev[EV_FORMAT])
      begin
        act_req = 1'b1;
        act_req_ua = 1'b1;
      end
    end
  end

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= HRESP_OKAY;
    end
    else
    begin
      wr_pend <= HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HWRITE;
      addr_q <= HADDR;
      HREADYOUT <= 1'b1;
      HRESP <= HRESP_OKAY;
    end
  end

  // read data registered in the address phase; unmapped reads zero
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      HRDATA <= 32'h0;
    else if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ && !HWRITE)
    begin
      case (HADDR)
        OFS_LEN: HRDATA <= len_reg;
        OFS_IMAGE: HRDATA <= 32'(image_size);
        OFS_RECEIVED: HRDATA <= 32'(received);
        OFS_STATUS: HRDATA <= {11'h0, ssu_pc_valid, low_power,
          act_state != ACT_IDLE, defer_kind != DEF_NONE, sel_bits,
          cmd_done, sense.check_condition, sense.sense_key, sense.asc};
        default: HRDATA <= 32'h0;
      endcase
    end
  end

  // length and image-size registers
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      len_reg <= 32'h0;
      image_size <= '0;
    end
    else if (wr_pend && addr_q == OFS_LEN)
      len_reg <= HWDATA;
    else if (wr_pend && addr_q == OFS_IMAGE)
      image_size <= HWDATA[LEN_W-1:0];
  end

  // command decode: sense result and segment tracking
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sense <= '0;
      cmd_done <= 1'b0;
      received <= '0;
      seg_restart <= 1'b1;
      seg_err_seen <= 1'b0;
      SAVE_STROBE <= 1'b0;
      ECHO_VALID <= 1'b0;
    end
    else
    begin
      SAVE_STROBE <= 1'b0;
      if (ev[EV_OTHER_CMD])
        ECHO_VALID <= 1'b0;
      if (cmd_go)
      begin
        cmd_done <= 1'b1;
        sense <= '0;
        case (mode)
          MODE_SEG:
          begin
            // buffer id only counts right after an error
            if (seg_err_seen && buf_id == BUF_ID_START)
              received <= '0;
            if (!seg_len_ok)
            begin
              sense <= '{1'b1, SK_ILLEGAL_REQUEST,
                ASC_INVALID_FIELD_CDB};
              seg_err_seen <= 1'b1;
            end
            else if (seg_complete ||
              (seg_err_seen && buf_id == BUF_ID_START &&
              len_reg[LEN_W-1:0] == image_size))
            begin
              SAVE_STROBE <= 1'b1;
              received <= '0;
              seg_restart <= 1'b1;
              seg_err_seen <= 1'b0;
            end
            else
            begin
              received <= ((seg_restart ||
                (seg_err_seen && buf_id == BUF_ID_START)) ?
                LEN_W'(0) : received) + len_reg[LEN_W-1:0];
              seg_restart <= 1'b0;
              seg_err_seen <= 1'b0;
            end
          end
          MODE_SAVE:
            SAVE_STROBE <= 1'b1;
          MODE_ECHO, MODE_EXPANDER:
          begin
            if (len_reg[ECHO_ALIGN_BITS-1:0] != '0)
              sense <= '{1'b1, SK_ILLEGAL_REQUEST,
                ASC_INVALID_FIELD_CDB};
            else
              ECHO_VALID <= 1'b1;
          end
          MODE_SEL_DEFER, MODE_DEFER, MODE_ACTIVATE: ;
          default:
            sense <= '{1'b1, SK_ILLEGAL_REQUEST,
              ASC_INVALID_FIELD_CDB};
        endcase
      end
    end
  end

  // self-initiated power-on reset after a save
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      SELF_RESET <= 1'b0;
    else
      SELF_RESET <= SAVE_STROBE;
  end

  // single pending flag; activation clears it
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      defer_kind <= DEF_NONE;
      sel_bits <= 3'h0;
    end
    else if (cmd_go && mode == MODE_SEL_DEFER)
    begin
      defer_kind <= DEF_SELECT;
      sel_bits <= {spec[PO_SEL_BIT], spec[HR_SEL_BIT],
        spec[VSE_SEL_BIT]};
    end
    else if (cmd_go && mode == MODE_DEFER)
    begin
      defer_kind <= DEF_PLAIN;
      sel_bits <= 3'h0;
    end
    else if (act_req && defer_kind != DEF_NONE)
      defer_kind <= DEF_NONE;
  end

  // activation sequencer: spin up first when in low power
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      act_state <= ACT_IDLE;
      act_via_ua <= 1'b0;
      act_via_ssu <= 1'b0;
      act_via_reset_fmt <= 1'b0;
      ssu_pc <= 4'h0;
      ssu_pc_valid <= 1'b0;
      ACTIVATE <= 1'b0;
      SPIN_UP <= 1'b0;
    end
    else
    begin
      ACTIVATE <= 1'b0;
      case (act_state)
        ACT_IDLE:
          if (act_req && defer_kind != DEF_NONE)
          begin
            act_via_ua <= act_req_ua;
            act_via_ssu <= ev[EV_SSU];
            act_via_reset_fmt <= ev[EV_HARD_RESET] || ev[EV_FORMAT];
            ssu_pc <= HWDATA[CMD_PC_LSB +: 4];
            ssu_pc_valid <= ev[EV_SSU] && HWDATA[CMD_PCV_BIT];
            if (low_power)
            begin
              SPIN_UP <= 1'b1;
              act_state <= ACT_SPIN;
            end
            else
              act_state <= ACT_FIRE;
          end
        ACT_SPIN:
          if (ev[EV_SPUN_UP])
          begin
            SPIN_UP <= 1'b0;
            act_state <= ACT_FIRE;
          end
        ACT_FIRE:
        begin
          ACTIVATE <= 1'b1;
          act_state <= ACT_IDLE;
        end
        default: act_state <= ACT_IDLE;
      endcase
    end
  end

  // power state tracking after activation
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      low_power <= 1'b0;
      POWER_COND <= PC_ACTIVE;
    end
    else if (ACTIVATE && act_via_ssu)
    begin
      low_power <= ev[EV_POWER_SAVE]; // a new request wins
      POWER_COND <= ssu_pc_valid ? ssu_pc : PC_ACTIVE;
    end
    else if (ACTIVATE && (act_via_reset_fmt || low_power))
    begin
      low_power <= ev[EV_POWER_SAVE];
      POWER_COND <= PC_ACTIVE;
    end
    else if (ev[EV_POWER_SAVE])
      low_power <= 1'b1;
  end

  // unit attention to all initiators; set wins over acknowledge
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      UNIT_ATTENTION <= 1'b0;
    else if (ACTIVATE && act_via_ua)
      UNIT_ATTENTION <= 1'b1;
    else if (ev[EV_UA_ACK])
      UNIT_ATTENTION <= 1'b0;
  end

  // checks
  a_bad_seg_sense: assert property (@(posedge MCLK)
    disable iff (RST) cmd_go && mode == MODE_SEG && !seg_len_ok |=>
    sense.check_condition && sense.asc == ASC_INVALID_FIELD_CDB)
    else $error("bad segment not rejected");
  a_bad_mode_sense: assert property (@(posedge MCLK)
    disable iff (RST) cmd_go && mode == 5'h1f |=> sense.check_condition &&
    sense.sense_key == SK_ILLEGAL_REQUEST)
    else $error("unsupported mode accepted");
  a_save_self_reset: assert property (@(posedge MCLK)
    disable iff (RST) SAVE_STROBE |=> SELF_RESET)
    else $error("no self reset after save");
  a_po_sel_gate: assert property (@(posedge MCLK)
    disable iff (RST) defer_kind == DEF_SELECT && !sel_bits[2] &&
    ev == 32'h1 && act_state == ACT_IDLE |=> defer_kind == DEF_SELECT)
    else $error("power on activated unselected code");
  a_hr_sel_gate: assert property (@(posedge MCLK)
    disable iff (RST) defer_kind == DEF_SELECT && sel_bits[1] && !low_power &&
    ev[EV_HARD_RESET] && act_state == ACT_IDLE |=> ##1 ACTIVATE)
    else $error("hard reset did not activate");
  a_plain_ssu_act: assert property (@(posedge MCLK)
    disable iff (RST) defer_kind == DEF_PLAIN && ev[EV_SSU] && !low_power &&
    act_state == ACT_IDLE |=> defer_kind == DEF_NONE ##1 ACTIVATE)
    else $error("start stop did not activate");
  a_spin_first: assert property (@(posedge MCLK)
    disable iff (RST) act_state == ACT_SPIN |-> SPIN_UP && !ACTIVATE)
    else $error("activated before spin up");
  a_ua_raise: assert property (@(posedge MCLK)
    disable iff (RST) ACTIVATE && act_via_ua |=> UNIT_ATTENTION)
    else $error("unit attention missing");
  a_none_pending: assert property (@(posedge MCLK)
    disable iff (RST) act_state == ACT_IDLE && defer_kind == DEF_NONE |=>
    act_state == ACT_IDLE ##1 !ACTIVATE)
    else $error("activation with nothing pending");
  c_seg_save: cover property (@(posedge MCLK) cmd_go && mode == MODE_SEG
    ##1 SAVE_STROBE);
  c_spin_activate: cover property (@(posedge MCLK)
    act_state == ACT_SPIN ##[1:20] ACTIVATE);
  c_echo: cover property (@(posedge MCLK) ECHO_VALID);
  c_ua: cover property (@(posedge MCLK) UNIT_ATTENTION);

endmodule // ucode_dl_ctrl
`default_nettype wire

/* File: rtl/ucode_dl_pkg.sv */
// constants and types shared by the microcode download block
// What this block does
// - bad segment length ends with illegal request, invalid field in CDB
// - first segment starts image; after error, buffer id 00h restarts it
// - buffer offset is ignored in segmented mode
// - when all segments are in, behave as download-and-save
// - saved code takes effect only after self-initiated power-on reset
// - echo write stores data in echo buffer, 4-byte aligned
// - echo contents kept until another command arrives
// - select mode saves code deferred; activate command 0Fh activates it
// - mode-specific bits 7,6,5 select power-on, hard-reset, vendor events
// - power on activates select-mode code only if power-on select set
// - hard reset activates select-mode code only if hard-reset select set
// - vendor event activates select-mode code only if its select set
// - plain deferred mode saves code and holds it deferred
// - plain deferred code activates on power on, reset, SSU, format, 0Fh
// - format or start-stop activates 0Eh code before processing command
// - in low-power state, spin up first, then activate
// - no return to power save after reset/format; SSU takes its condition
// - reset, start-stop or format activation raises unit attention to all
// - activate mode activates pending code, ignoring id, offset, length
// - expander-communications mode behaves as echo-buffer write
// - unsupported mode codes end with illegal request, invalid field
package ucode_dl_pkg;
  localparam logic [4:0] MODE_SAVE = 5'h05;
  localparam logic [4:0] MODE_SEG = 5'h07;
  localparam logic [4:0] MODE_ECHO = 5'h0a;
  localparam logic [4:0] MODE_SEL_DEFER = 5'h0d;
  localparam logic [4:0] MODE_DEFER = 5'h0e;
  localparam logic [4:0] MODE_ACTIVATE = 5'h0f;
  localparam logic [4:0] MODE_EXPANDER = 5'h1a;
  localparam int SEG_ALIGN_BITS = 12;
  localparam int ECHO_ALIGN_BITS = 2;
  localparam int PO_SEL_BIT = 7;
  localparam int HR_SEL_BIT = 6;
  localparam int VSE_SEL_BIT = 5;
  localparam logic [7:0] BUF_ID_START = 8'h00;
  // register map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LEN = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IMAGE = 8'h10;
  localparam logic [7:0] OFS_RECEIVED = 8'h14;
  // command word fields
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_ID_LSB = 8;
  localparam int CMD_SPEC_LSB = 16;
  localparam int CMD_PC_LSB = 24;
  localparam int CMD_PCV_BIT = 28;
  localparam int CMD_GO_BIT = 31;
  // event word bits (write one to signal)
  localparam int EV_POWER_ON = 0;
  localparam int EV_HARD_RESET = 1;
  localparam int EV_VENDOR = 2;
  localparam int EV_SSU = 3;
  localparam int EV_FORMAT = 4;
  localparam int EV_OTHER_CMD = 5;
  localparam int EV_POWER_SAVE = 6;
  localparam int EV_SPUN_UP = 7;
  localparam int EV_UA_ACK = 8;
  localparam logic [3:0] PC_ACTIVE = 4'h1;
  localparam logic [1:0] HRESP_OKAY = 2'b00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef enum logic [1:0] {
    DEF_NONE,
    DEF_SELECT,
    DEF_PLAIN
  } defer_kind_type;

  typedef struct packed {
    logic check_condition;
    logic [3:0] sense_key;
    logic [7:0] asc;
  } sense_type;

  localparam logic [3:0] SK_ILLEGAL_REQUEST = 4'h5;
  localparam logic [7:0] ASC_INVALID_FIELD_CDB = 8'h24;
endpackage

/* File: sim/scsi_initiator_model.sv */
// initiator model issuing buffer-write commands over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module scsi_initiator_model
  import ucode_dl_pkg::*;
(
  input wire logic mclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // bus idle at time zero
  initial
  begin
    hsel <= 1'b0;
    haddr <= 8'h00;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= HSIZE_WORD;
    hwdata <= 32'h0;
  end

  // single transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d; // released data never repeats the last word
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  // length goes first, the command word with go set starts it
  task automatic cmd(input logic [4:0] m, input logic [7:0] id,
                     input logic [7:0] spec, input logic [31:0] len);
    wr(OFS_LEN, len);
    wr(OFS_CMD, {1'b1, 7'h00, spec, id, 3'h0, m});
  endtask

  // whole image: random 4k-multiple segments (4k to 12k each) summing to the total
  task automatic image(input int segs, input logic [7:0] id0,
                       inout int seed);
    int lens [8];
    int total;
    total = 0;
    for (int i = 0; i < segs; i++)
    begin
      lens[i] = (1 + ($unsigned($random(seed)) % 3)) * 4096;
      total += lens[i];
    end
    wr(OFS_IMAGE, 32'(total));
    for (int i = 0; i < segs; i++)
      cmd(MODE_SEG, (i == 0) ? id0 : 8'h5a, 8'h00, 32'(lens[i]));
  endtask
endmodule // scsi_initiator_model
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the microcode download controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ucode_dl_pkg::*;
;
  logic mclk;
  logic rst;
  logic hsel;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic [1:0] hresp;
  logic save;
  logic self_reset;
  logic activate;
  logic spin_up;
  logic ua;
  logic echo;
  logic [3:0] pc;
  logic prev_save;
  logic [31:0] s;
  int fail_count;
  int comparisons;
  int seed;
  int n_save;
  int n_act;

  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
  end
  always #4 mclk = ~mclk;

  ucode_dl_ctrl dut (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready),
    .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .SAVE_STROBE(save), .SELF_RESET(self_reset), .ACTIVATE(activate),
    .SPIN_UP(spin_up), .UNIT_ATTENTION(ua), .ECHO_VALID(echo),
    .POWER_COND(pc));

  scsi_initiator_model init (.mclk(mclk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen,
               exp);
    end
  endtask

  // select-mode activation expected for select pattern p and event index v
  function automatic int sel_expect(input int p, input int v);
    return (p >> (2 - v)) & 1;
  endfunction

  task automatic final_report();
    $display("counts: %0d compared, %0d wrong", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // a few cycles let pulses and status settle before the read
  task automatic stat();
    idle(4);
    init.rd(OFS_STATUS, s);
  endtask

  task automatic ev(input int b);
    init.wr(OFS_EVENT, 32'h1 << b);
  endtask

  task automatic cc(input logic e);
    stat();
    chk(32'(s[12]), 32'(e), "check condition");
    chk(32'(s[13]), 32'h1, "command done");
    if (e)
      chk(32'(s[11:0]), {20'h0, SK_ILLEGAL_REQUEST, ASC_INVALID_FIELD_CDB},
          "sense");
  endtask

  // count pulses; self reset must trail each save by one cycle
  always @(posedge mclk)
  begin
    if (save === 1'b1)
      n_save++;
    if (activate === 1'b1)
      n_act++;
    if (prev_save === 1'b1)
      chk(32'(self_reset), 32'h1, "self reset after save");
    prev_save = save;
  end

  // watchdog well beyond the fewer than two thousand cycles the tests need
  initial
  begin
    idle(50000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  initial
  begin
    int a;
    int e;
    logic [4:0] m;
    logic [31:0] evw [7];
    logic [3:0] pcx [7];
    logic uax [7];
    evw = '{32'h1, 32'h2, 32'h1200_0008, 32'h8, 32'h1200_0008, 32'h10, 0};
    pcx = '{4'h0, 4'h0, 4'h2, 4'h1, 4'h2, 4'h1, 4'h0};
    uax = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    seed = 47;
    idle(8);
    rst <= 1'b0;
    idle(1);
    chk({24'h0, hready, save, activate, spin_up, ua, echo, hresp}, 32'h80,
        "idle outs");
    chk(32'(pc), 32'(PC_ACTIVE), "reset power cond");
    stat();
    chk(32'(s[17]), 32'h0, "nothing pending");
    init.rd(8'h1c, s);
    chk(s, 32'h0, "unmapped read");
    a = n_save;
    init.cmd(MODE_SAVE, BUF_ID_START, 8'h00, 32'h1000);
    cc(1'b0);
    chk(32'(n_save - a), 32'h1, "single save");
    $display("test save done");
    for (int r = 0; r < 3; r++)
    begin
      a = n_save;
      init.image(1 + ($unsigned($random(seed)) % 4), 8'($random(seed)), seed);
      cc(1'b0);
      chk(32'(n_save - a), 32'h1, "image saved once");
      init.rd(OFS_RECEIVED, s);
      chk(s, 32'h0, "received cleared");
    end
    // bad lengths mid-image, then restart with id 00h
    init.wr(OFS_IMAGE, 32'h3000);
    init.cmd(MODE_SEG, 8'h21, 8'h00, 32'h1000);
    a = n_save;
    init.cmd(MODE_SEG, 8'h22, 8'h00, 32'h1004);
    cc(1'b1);
    init.cmd(MODE_SEG, 8'h23, 8'h00, 32'h0);
    cc(1'b1);
    init.cmd(MODE_SEG, BUF_ID_START, 8'h00, 32'h1000);
    init.cmd(MODE_SEG, 8'h24, 8'h00, 32'h1000);
    stat();
    chk(32'(n_save - a), 32'h0, "restart not complete");
    init.rd(OFS_RECEIVED, s);
    chk(s, 32'h2000, "received after restart");
    init.cmd(MODE_SEG, 8'h25, 8'h00, 32'h1000);
    stat();
    chk(32'(n_save - a), 32'h1, "restart complete");
    $display("test segmented done");
    for (int i = 0; i < 2; i++)
    begin
      m = i ? MODE_EXPANDER : MODE_ECHO;
      init.cmd(m, 8'($random(seed)), 8'h00,
               32'(4 * (1 + $unsigned($random(seed)) % 64)));
      cc(1'b0);
      chk(32'(echo), 32'h1, "echo kept");
      ev(EV_OTHER_CMD);
      idle(4);
      chk(32'(echo), 32'h0, "echo dropped");
      init.cmd(m, 8'h00, 8'h00, 32'h6);
      cc(1'b1);
    end
    $display("test echo done");
    for (int i = 0; i < 32; i++)
    begin
      m = 5'(i);
      if (!(m inside {MODE_SAVE, MODE_SEG, MODE_ECHO, MODE_SEL_DEFER,
            MODE_DEFER, MODE_ACTIVATE, MODE_EXPANDER, 5'h00, 5'h02, 5'h04}))
      begin
        init.cmd(m, 8'($random(seed)), 8'h00, 32'h1000);
        cc(1'b1);
      end
    end
    $display("test unsupported done");
    // every select pattern against each of its three events
    for (int k = 0; k < 24; k++)
    begin
      init.cmd(MODE_SEL_DEFER, 8'($random(seed)), 8'((k / 3) << 5), 32'h1000);
      stat();
      chk(32'(s[17]), 32'h1, "select pending");
      chk(32'(s[16:14]), 32'(k / 3), "select bits");
      a = n_act;
      ev((k % 3 == 0) ? EV_POWER_ON : (k % 3 == 1) ? EV_HARD_RESET : EV_VENDOR);
      stat();
      e = sel_expect(k / 3, k % 3);
      chk(32'(n_act - a), 32'(e), "event act");
      chk(32'(s[17]), 32'(!e), "event pending");
      init.cmd(MODE_ACTIVATE, 8'($random(seed)), 8'h00, 32'($random(seed)));
      init.cmd(MODE_ACTIVATE, 8'h00, 8'h00, 32'h0);
      stat();
      chk(32'(n_act - a), 32'h1, "one activation");
      chk(32'(s[17]), 32'h0, "cleared");
      ev(EV_UA_ACK);
    end
    $display("test select done");
    for (int k = 0; k < 7; k++)
    begin
      init.cmd(MODE_DEFER, 8'($random(seed)), 8'h00, 32'h2000);
      stat();
      chk(32'(s[17]), 32'h1, "plain pending");
      a = n_act;
      if (evw[k] != 0)
        init.wr(OFS_EVENT, evw[k]);
      else
        init.cmd(MODE_ACTIVATE, 8'h00, 8'h00, 32'h0);
      stat();
      chk(32'(n_act - a), 32'h1, "plain act");
      chk(32'(s[17]), 32'h0, "plain cleared");
      chk(32'(ua), 32'(uax[k]), "attention");
      if (pcx[k] != 0)
        chk(32'(pc), 32'(pcx[k]), "power cond");
      ev(EV_UA_ACK);
      idle(4);
      chk(32'(ua), 32'h0, "attention acked");
    end
    $display("test plain done");
    init.cmd(MODE_DEFER, 8'h00, 8'h00, 32'h1000);
    ev(EV_POWER_SAVE);
    stat();
    chk(32'(s[19]), 32'h1, "low power");
    a = n_act;
    ev(EV_HARD_RESET);
    idle(8);
    chk(32'(spin_up), 32'h1, "spin up asked");
    chk(32'(n_act - a), 32'h0, "waits for spin");
    ev(EV_SPUN_UP);
    stat();
    chk(32'(n_act - a), 32'h1, "act after spin");
    chk({31'h0, s[19]}, 32'h0, "not back to low power");
    chk(32'(spin_up), 32'h0, "spin released");
    $display("test spin done");
    final_report();
  end
endmodule // tb_top
`default_nettype wire
